// ---- src/usc_pkg.sv ----
// usc_pkg: register map, field positions, states and size decode of the serial port
// Overview of operation
// - receive enable on turns receiver on and takes over receive pin
// - receive enable off flushes buffer and clears frame, overrun, parity flags
// - transmit enable on turns transmitter on and takes over transmit pin
// - transmit disable waits until shift register and buffer are empty
// - three-bit size code gives 5, 6, 7, 8 or 9 data bits
// - ninth received bit shows in control b bit 1, read before data
// - control b bit 0 is ninth sent bit, written before data
// - mode select 0 is asynchronous, 1 is synchronous
// - parity field 00 off, 01 reserved, 10 even, 11 odd
// - transmitter appends computed parity bit to each frame
// - receiver checks parity and flags mismatch as parity error
// - stop select gives one or two sent stop bits; receiver ignores it
// - synchronous polarity picks clock edges for sending and sampling
// - baud divisor is twelve bits over high and low byte registers
// - writing low divisor byte reloads the prescaler at once
// - double speed halves oversampling from sixteen to eight, asynchronous only
// - frame error marks buffered character whose first stop bit was zero
package usc_pkg;
  localparam logic [7:0] OFS_CTRL_A = 8'h00;
  localparam logic [7:0] OFS_CTRL_B = 8'h04;
  localparam logic [7:0] OFS_CTRL_C = 8'h08;
  localparam logic [7:0] OFS_BAUD_H = 8'h0c;
  localparam logic [7:0] OFS_BAUD_L = 8'h10;
  localparam logic [7:0] OFS_DATA = 8'h14;
  localparam int CA_RX_DONE = 7;
  localparam int CA_TX_EMPTY = 5;
  localparam int CA_FRAME_ERR = 4;
  localparam int CA_OVERRUN = 3;
  localparam int CA_PARITY_ERR = 2;
  localparam int CA_DOUBLE_SPEED = 1;
  localparam int CB_RX_ENABLE = 4;
  localparam int CB_TX_ENABLE = 3;
  localparam int CB_SIZE_HI = 2;
  localparam int CB_RX_NINTH = 1;
  localparam int CB_TX_NINTH = 0;
  localparam int CC_SYNC_MODE = 6;
  localparam int CC_PAR_HI = 5;
  localparam int CC_PAR_LO = 4;
  localparam int CC_STOP_SEL = 3;
  localparam int CC_SIZE_HI = 2;
  localparam int CC_SIZE_LO = 1;
  localparam int CC_CLK_POL = 0;
  localparam logic [7:0] RST_CTRL_B = 8'h00;
  localparam logic [7:0] RST_CTRL_C = 8'h06;
  localparam logic [11:0] RST_BAUD = 12'h000;
  localparam logic [4:0] OS_NORMAL = 5'h10;
  localparam logic [4:0] OS_DOUBLE = 5'h08;
  localparam int ENTRY_PE = 10;
  localparam int ENTRY_FE = 9;

  typedef enum logic [2:0] {TX_IDLE = 3'b000, TX_START = 3'b001, TX_DATA = 3'b010,
                            TX_PAR = 3'b011, TX_STOP1 = 3'b100, TX_STOP2 = 3'b101} usc_tx_e;
  typedef enum logic [2:0] {RX_IDLE = 3'b000, RX_START = 3'b001, RX_DATA = 3'b010,
                            RX_PAR = 3'b011, RX_STOP = 3'b100} usc_rx_e;

  // reserved size codes fall back to eight bits
  function automatic logic [3:0] usc_char_bits(input logic [2:0] code);
    unique case (code)
      3'b000: usc_char_bits = 4'h5;
      3'b001: usc_char_bits = 4'h6;
      3'b010: usc_char_bits = 4'h7;
      3'b111: usc_char_bits = 4'h9;
      default: usc_char_bits = 4'h8;
    endcase
  endfunction
endpackage

// ---- src/usc_baud.sv ----
// usc_baud: reloadable twelve-bit baud prescaler
`timescale 1ns/1ps
module usc_baud
  import usc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] divisor,
  input wire logic reload,
  output logic tick
);
  logic [11:0] cnt_r;
  logic [11:0] cnt_nxt;

  always_comb begin
    cnt_nxt = cnt_r - 12'h001;
    if (reload || cnt_r == 12'h000) begin
      cnt_nxt = divisor;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= RST_BAUD;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // one tick per divisor plus one clocks
  assign tick = (cnt_r == 12'h000) && !reload;

  property p_reload;
    // a zero divisor ticks on every clock, so only a nonzero one must skip a tick
    @(posedge pclk) disable iff (!presetn)
      reload |=> (cnt_r == $past(divisor)) && (!tick || $past(divisor) == 12'h000);
  endproperty
  a_reload: assert property (p_reload) else $error("prescaler not reloaded");
endmodule // usc_baud

// ---- src/usc_rxbuf.sv ----
// usc_rxbuf: two-entry receive buffer holding data with its error bits
`timescale 1ns/1ps
module usc_rxbuf
  import usc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic push,
  input wire logic [10:0] push_data,
  input wire logic pop,
  input wire logic flush,
  output logic overrun,
  output logic [1:0] count,
  output logic [10:0] head
);
  logic [10:0] mem_r [2];
  logic [10:0] mem_nxt [2];
  logic rd_r;
  logic rd_nxt;
  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;
  logic do_pop;
  logic wr_idx;

  always_comb begin
    mem_nxt = mem_r;
    rd_nxt = rd_r;
    cnt_nxt = cnt_r;
    do_pop = pop && (cnt_r != 2'h0);
    // a full buffer that is read in the same cycle still takes the new entry
    wr_idx = rd_r ^ cnt_r[0];
    overrun = push && (cnt_r == 2'h2) && !do_pop && !flush;
    if (flush) begin
      rd_nxt = 1'b0;
      cnt_nxt = 2'h0;
    end else begin
      if (do_pop) begin
        rd_nxt = !rd_r;
      end
      if (push && !overrun) begin
        mem_nxt[wr_idx] = push_data;
      end
      cnt_nxt = cnt_r + {1'b0, push && !overrun} - {1'b0, do_pop};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_r[0] <= 11'h000;
      mem_r[1] <= 11'h000;
      rd_r <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      mem_r <= mem_nxt;
      rd_r <= rd_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign count = cnt_r;
  assign head = mem_r[rd_r];
endmodule // usc_rxbuf

// ---- src/usc_core.sv ----
// usc_core: apb registers, transmitter and receiver of the serial port
//
// Decided for this implementation: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module usc_core
  import usc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_data_in,
  output logic rx_pin_takeover,
  output logic tx_data_out,
  output logic tx_pin_takeover,
  output logic sync_serial_clock,
  output logic sync_clock_oe
);
  // register state
  logic rx_enable_r, rx_enable_nxt;
  logic tx_enable_r, tx_enable_nxt;
  logic size_hi_r, size_hi_nxt;
  logic tx_ninth_r, tx_ninth_nxt;
  logic double_speed_r, double_speed_nxt;
  logic [6:0] ctrl_c_r, ctrl_c_nxt;
  logic [11:0] baud_r, baud_nxt;
  logic [8:0] txbuf_r, txbuf_nxt;
  logic txbuf_full_r, txbuf_full_nxt;
  logic dor_r, dor_nxt;
  logic [7:0] prdata_r, prdata_nxt;
  logic pslverr_r, pslverr_nxt;
  // bit timing
  logic xck_r, xck_nxt;
  logic [4:0] tx_os_r, tx_os_nxt;
  // transmitter
  usc_tx_e tx_state_r, tx_state_nxt;
  logic [8:0] tx_sh_r, tx_sh_nxt;
  logic [3:0] tx_left_r, tx_left_nxt;
  logic tx_par_r, tx_par_nxt;
  logic tx_out_r, tx_out_nxt;
  logic tx_run_r, tx_run_nxt;
  // receiver
  usc_rx_e rx_state_r, rx_state_nxt;
  logic [8:0] rx_sh_r, rx_sh_nxt;
  logic [3:0] rx_idx_r, rx_idx_nxt;
  logic [4:0] rx_os_r, rx_os_nxt;
  logic rx_par_r, rx_par_nxt;
  // combinational
  logic wr_acc, rd_acc, setup, tick, baud_reload;
  logic sync_mode, par_on, par_odd, two_stop, clk_pol;
  logic [3:0] n_bits;
  logic [8:0] d_mask;
  logic [4:0] os, os_last;
  logic tx_step, rx_samp, tx_load;
  logic rx_push, rx_pop, rx_overrun;
  logic [10:0] rx_push_data, rx_head;
  logic [1:0] rx_count;

  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign setup = psel && !penable;
  assign sync_mode = ctrl_c_r[CC_SYNC_MODE];
  assign par_on = ctrl_c_r[CC_PAR_HI];
  assign par_odd = ctrl_c_r[CC_PAR_LO];
  assign two_stop = ctrl_c_r[CC_STOP_SEL];
  // polarity only used in synchronous mode
  assign clk_pol = ctrl_c_r[CC_CLK_POL] && sync_mode;
  // data bit count from split size code
  assign n_bits = usc_char_bits({size_hi_r, ctrl_c_r[CC_SIZE_HI:CC_SIZE_LO]});
  assign d_mask = ~(9'h1ff << n_bits);
  assign os = (double_speed_r && !sync_mode) ? OS_DOUBLE : OS_NORMAL;
  assign os_last = os - 5'h01;
  assign baud_reload = wr_acc && (paddr == OFS_BAUD_L);
  assign rx_pop = rd_acc && (paddr == OFS_DATA);

  usc_baud u_baud (
    .pclk(pclk),
    .presetn(presetn),
    .divisor(baud_nxt),
    .reload(baud_reload),
    .tick(tick)
  );

  usc_rxbuf u_rxbuf (
    .pclk(pclk),
    .presetn(presetn),
    .push(rx_push),
    .push_data(rx_push_data),
    .pop(rx_pop),
    .flush(!rx_enable_r),
    .overrun(rx_overrun),
    .count(rx_count),
    .head(rx_head)
  );

  // registers and bus answer
  always_comb begin
    rx_enable_nxt = rx_enable_r;
    tx_enable_nxt = tx_enable_r;
    size_hi_nxt = size_hi_r;
    tx_ninth_nxt = tx_ninth_r;
    double_speed_nxt = double_speed_r;
    ctrl_c_nxt = ctrl_c_r;
    baud_nxt = baud_r;
    txbuf_nxt = txbuf_r;
    txbuf_full_nxt = txbuf_full_r && !tx_load;
    prdata_nxt = prdata_r;
    pslverr_nxt = 1'b0;
    if (wr_acc) begin
      unique case (paddr)
        OFS_CTRL_A: double_speed_nxt = pwdata[CA_DOUBLE_SPEED];
        OFS_CTRL_B: begin
          rx_enable_nxt = pwdata[CB_RX_ENABLE];
          tx_enable_nxt = pwdata[CB_TX_ENABLE];
          size_hi_nxt = pwdata[CB_SIZE_HI];
          tx_ninth_nxt = pwdata[CB_TX_NINTH];
        end
        OFS_CTRL_C: ctrl_c_nxt = pwdata[6:0];
        OFS_BAUD_H: baud_nxt[11:8] = pwdata[3:0];
        OFS_BAUD_L: baud_nxt[7:0] = pwdata[7:0];
        OFS_DATA: begin
          if (!txbuf_full_r) begin
            txbuf_nxt = {tx_ninth_r, pwdata[7:0]};
            txbuf_full_nxt = 1'b1;
          end
        end
        default: ;
      endcase
    end
    // read data is fetched in the setup phase so that it leaves a flip-flop
    if (setup) begin
      prdata_nxt = 8'h00;
      unique case (paddr)
        OFS_CTRL_A: begin
          prdata_nxt[CA_RX_DONE] = rx_count != 2'h0;
          prdata_nxt[CA_TX_EMPTY] = !txbuf_full_r;
          prdata_nxt[CA_FRAME_ERR] = rx_head[ENTRY_FE] && rx_count != 2'h0;
          prdata_nxt[CA_OVERRUN] = dor_r;
          prdata_nxt[CA_PARITY_ERR] = rx_head[ENTRY_PE] && rx_count != 2'h0;
          prdata_nxt[CA_DOUBLE_SPEED] = double_speed_r;
        end
        OFS_CTRL_B: begin
          prdata_nxt[CB_RX_ENABLE] = rx_enable_r;
          prdata_nxt[CB_TX_ENABLE] = tx_enable_r;
          prdata_nxt[CB_SIZE_HI] = size_hi_r;
          prdata_nxt[CB_RX_NINTH] = rx_head[8];
          prdata_nxt[CB_TX_NINTH] = tx_ninth_r;
        end
        OFS_CTRL_C: prdata_nxt = {1'b0, ctrl_c_r};
        OFS_BAUD_H: prdata_nxt = {4'h0, baud_r[11:8]};
        OFS_BAUD_L: prdata_nxt = baud_r[7:0];
        OFS_DATA: prdata_nxt = rx_head[7:0];
        default: pslverr_nxt = 1'b1;
      endcase
    end
    // disabling receiver clears overrun
    // overrun set wins over the clear by a read
    if (!rx_enable_r) begin
      dor_nxt = 1'b0;
    end else begin
      dor_nxt = rx_overrun || (dor_r && !rx_pop);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_enable_r <= RST_CTRL_B[CB_RX_ENABLE];
      tx_enable_r <= RST_CTRL_B[CB_TX_ENABLE];
      size_hi_r <= RST_CTRL_B[CB_SIZE_HI];
      tx_ninth_r <= RST_CTRL_B[CB_TX_NINTH];
      double_speed_r <= 1'b0;
      ctrl_c_r <= RST_CTRL_C[6:0];
      baud_r <= RST_BAUD;
      txbuf_r <= 9'h000;
      txbuf_full_r <= 1'b0;
      dor_r <= 1'b0;
      prdata_r <= 8'h00;
      pslverr_r <= 1'b0;
    end else begin
      rx_enable_r <= rx_enable_nxt;
      tx_enable_r <= tx_enable_nxt;
      size_hi_r <= size_hi_nxt;
      tx_ninth_r <= tx_ninth_nxt;
      double_speed_r <= double_speed_nxt;
      ctrl_c_r <= ctrl_c_nxt;
      baud_r <= baud_nxt;
      txbuf_r <= txbuf_nxt;
      txbuf_full_r <= txbuf_full_nxt;
      dor_r <= dor_nxt;
      prdata_r <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign prdata = {24'h000000, prdata_r};
  assign pready = 1'b1;
  assign pslverr = pslverr_r && psel && penable;

  // bit timing: synchronous clock is half the prescaler tick rate
  always_comb begin
    xck_nxt = sync_mode ? (xck_r ^ tick) : 1'b0;
    tx_os_nxt = tx_os_r;
    if (tick) begin
      tx_os_nxt = (tx_os_r >= os_last) ? 5'h00 : tx_os_r + 5'h01;
    end
    if (sync_mode) begin
      tx_step = tick && (xck_r == clk_pol);
      rx_samp = tick && (xck_r != clk_pol);
    end else begin
      tx_step = tick && (tx_os_r >= os_last);
      rx_samp = tick && (rx_os_r >= os_last);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xck_r <= 1'b0;
      tx_os_r <= 5'h00;
    end else begin
      xck_r <= xck_nxt;
      tx_os_r <= tx_os_nxt;
    end
  end

  assign sync_serial_clock = xck_r;
  assign sync_clock_oe = sync_mode && (tx_run_r || rx_enable_r);

  // transmitter
  always_comb begin
    tx_state_nxt = tx_state_r;
    tx_sh_nxt = tx_sh_r;
    tx_left_nxt = tx_left_r;
    tx_par_nxt = tx_par_r;
    tx_out_nxt = tx_out_r;
    tx_load = 1'b0;
    // release only when nothing is left to send
    if (tx_enable_r) begin
      tx_run_nxt = 1'b1;
    end else begin
      tx_run_nxt = tx_run_r && !(tx_state_r == TX_IDLE && !txbuf_full_r);
    end
    if (tx_step) begin
      unique case (tx_state_r)
        TX_IDLE: begin
          tx_out_nxt = 1'b1;
          if (tx_run_r && txbuf_full_r) begin
            tx_load = 1'b1;
            tx_sh_nxt = txbuf_r & d_mask;
            tx_left_nxt = n_bits;
            tx_par_nxt = (^(txbuf_r & d_mask)) ^ par_odd;
            tx_out_nxt = 1'b0;
            tx_state_nxt = TX_START;
          end
        end
        TX_START, TX_DATA: begin
          if (tx_left_r != 4'h0) begin
            tx_out_nxt = tx_sh_r[0];
            tx_sh_nxt = {1'b0, tx_sh_r[8:1]};
            tx_left_nxt = tx_left_r - 4'h1;
            tx_state_nxt = TX_DATA;
          end else if (par_on) begin
            tx_out_nxt = tx_par_r;
            tx_state_nxt = TX_PAR;
          end else begin
            tx_out_nxt = 1'b1;
            tx_state_nxt = TX_STOP1;
          end
        end
        TX_PAR: begin
          tx_out_nxt = 1'b1;
          tx_state_nxt = TX_STOP1;
        end
        TX_STOP1: tx_state_nxt = two_stop ? TX_STOP2 : TX_IDLE;
        TX_STOP2: tx_state_nxt = TX_IDLE;
        default: tx_state_nxt = TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state_r <= TX_IDLE;
      tx_sh_r <= 9'h000;
      tx_left_r <= 4'h0;
      tx_par_r <= 1'b0;
      tx_out_r <= 1'b1;
      tx_run_r <= 1'b0;
    end else begin
      tx_state_r <= tx_state_nxt;
      tx_sh_r <= tx_sh_nxt;
      tx_left_r <= tx_left_nxt;
      tx_par_r <= tx_par_nxt;
      tx_out_r <= tx_out_nxt;
      tx_run_r <= tx_run_nxt;
    end
  end

  assign tx_data_out = tx_out_r;
  assign tx_pin_takeover = tx_run_r;
  assign rx_pin_takeover = rx_enable_r;

  // receiver; the stop select is not looked at here
  always_comb begin
    rx_state_nxt = rx_state_r;
    rx_sh_nxt = rx_sh_r;
    rx_idx_nxt = rx_idx_r;
    rx_par_nxt = rx_par_r;
    rx_os_nxt = rx_os_r;
    rx_push = 1'b0;
    // first stop bit low gives frame error
    rx_push_data = {par_on && ((^rx_sh_r) ^ par_odd ^ rx_par_r), !rx_data_in, rx_sh_r};
    if (tick) begin
      rx_os_nxt = (rx_os_r >= os_last) ? 5'h00 : rx_os_r + 5'h01;
    end
    unique case (rx_state_r)
      RX_IDLE: begin
        rx_sh_nxt = 9'h000;
        rx_idx_nxt = 4'h0;
        if (sync_mode && rx_samp && !rx_data_in) begin
          rx_state_nxt = RX_DATA;
        end else if (!sync_mode && !rx_data_in) begin
          // half a bit to reach the middle of the start bit
          rx_os_nxt = os >> 1;
          rx_state_nxt = RX_START;
        end
      end
      RX_START: begin
        if (rx_samp) begin
          rx_state_nxt = rx_data_in ? RX_IDLE : RX_DATA;
        end
      end
      RX_DATA: begin
        if (rx_samp) begin
          rx_sh_nxt[rx_idx_r] = rx_data_in;
          rx_idx_nxt = rx_idx_r + 4'h1;
          if (rx_idx_r + 4'h1 >= n_bits) begin
            rx_state_nxt = par_on ? RX_PAR : RX_STOP;
          end
        end
      end
      RX_PAR: begin
        if (rx_samp) begin
          rx_par_nxt = rx_data_in;
          rx_state_nxt = RX_STOP;
        end
      end
      RX_STOP: begin
        if (rx_samp) begin
          rx_push = 1'b1;
          rx_state_nxt = RX_IDLE;
        end
      end
      default: rx_state_nxt = RX_IDLE;
    endcase
    if (!rx_enable_r) begin
      rx_state_nxt = RX_IDLE;
      rx_push = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state_r <= RX_IDLE;
      rx_sh_r <= 9'h000;
      rx_idx_r <= 4'h0;
      rx_os_r <= 5'h00;
      rx_par_r <= 1'b0;
    end else begin
      rx_state_r <= rx_state_nxt;
      rx_sh_r <= rx_sh_nxt;
      rx_idx_r <= rx_idx_nxt;
      rx_os_r <= rx_os_nxt;
      rx_par_r <= rx_par_nxt;
    end
  end

  property p_rx_take;
    @(posedge pclk) disable iff (!presetn)
      (wr_acc && paddr == OFS_CTRL_B && pwdata[CB_RX_ENABLE]) |=> rx_pin_takeover;
  endproperty
  a_rx_take: assert property (p_rx_take) else $error("receive pin not taken");

  property p_rx_flush;
    @(posedge pclk) disable iff (!presetn) $fell(rx_pin_takeover) |=> (rx_count == 2'h0) && !dor_r;
  endproperty
  a_rx_flush: assert property (p_rx_flush) else $error("receive buffer not flushed");

  property p_tx_take;
    // takeover follows the registered enable, one clock after it
    @(posedge pclk) disable iff (!presetn)
      (wr_acc && paddr == OFS_CTRL_B && pwdata[CB_TX_ENABLE]) |-> ##2 tx_pin_takeover;
  endproperty
  a_tx_take: assert property (p_tx_take) else $error("transmit pin not taken");

  property p_tx_hold;
    @(posedge pclk) disable iff (!presetn)
      $fell(tx_pin_takeover) |-> $past(tx_state_r == TX_IDLE && !txbuf_full_r && !tx_enable_r);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("transmit pin released early");

  property p_tx_bits;
    @(posedge pclk) disable iff (!presetn) tx_load |=> tx_left_r == $past(n_bits) && tx_state_r == TX_START;
  endproperty
  a_tx_bits: assert property (p_tx_bits) else $error("wrong data bit count");

  property p_tx_par;
    @(posedge pclk) disable iff (!presetn)
      (tx_load && par_on) |=> tx_par_r == $past((^(txbuf_r & d_mask)) ^ par_odd);
  endproperty
  a_tx_par: assert property (p_tx_par) else $error("wrong parity bit");

  property p_stop;
    @(posedge pclk) disable iff (!presetn)
      (tx_state_r == TX_STOP1 && tx_step && !two_stop) |=> tx_state_r == TX_IDLE;
  endproperty
  a_stop: assert property (p_stop) else $error("extra stop bit sent");

  property p_sync_edge;
    @(posedge pclk) disable iff (!presetn) (sync_mode && $changed(tx_data_out)) |-> sync_serial_clock != clk_pol;
  endproperty
  a_sync_edge: assert property (p_sync_edge) else $error("transmit data off its clock edge");
endmodule // usc_core

// ---- sim/usc_remote.sv ----
// usc_remote: far serial station that sends and samples raw bit strings
`timescale 1ns/1ps
module usc_remote (
  input wire logic pclk,
  input wire logic tx_line,
  output logic rx_line
);
  initial rx_line = 1'b1;

  // start bit, then n bits lsb first; the line idles high for one bit after
  task automatic send(input logic [11:0] bits, input int n, input int per);
    logic [12:0] f;
    f = {bits, 1'b0};
    for (int i = 0; i <= n; i++) begin
      @(posedge pclk);
      rx_line <= f[i];
      repeat (per - 1) @(posedge pclk);
    end
    @(posedge pclk);
    rx_line <= 1'b1;
    repeat (per) @(posedge pclk);
  endtask

  // samples n bits after the start bit at mid-bit; limited to 12 bits
  task automatic capture(input int n, input int per, output logic [11:0] bits);
    int w;
    bits = '0;
    w = 0;
    while (tx_line !== 1'b0 && w < 4000) begin
      @(posedge pclk);
      w++;
    end
    repeat (per / 2) @(posedge pclk);
    for (int i = 0; i < n; i++) begin
      repeat (per) @(posedge pclk);
      bits[i] = tx_line;
    end
    // let the last stop bit run out before software touches the format
    repeat (per / 2 + 1) @(posedge pclk);
    if (w >= 4000) bits = 'x;
  endtask
endmodule // usc_remote

// ---- sim/tb_top.sv ----
// tb_top: register, frame format, rate and pin takeover tests of the serial port
`timescale 1ns/1ps
module tb_top
  import usc_pkg::*;
();
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, rx_line, tx_data_out, rx_pin_takeover, tx_pin_takeover;
  logic sync_serial_clock, sync_clock_oe;
  int fails = 0, checks = 0, cyc = 0;

  usc_core usc_core_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_data_in(rx_line), .rx_pin_takeover(rx_pin_takeover), .tx_data_out(tx_data_out),
    .tx_pin_takeover(tx_pin_takeover), .sync_serial_clock(sync_serial_clock), .sync_clock_oe(sync_clock_oe));
  usc_remote usc_remote_inst (.pclk(pclk), .tx_line(tx_data_out), .rx_line(rx_line));

  initial begin
    forever #4 pclk = ~pclk;
  end

  task tally_and_finish();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) fails++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    check(r, exp, "read data");
    check(32'(e), 32'(a > OFS_DATA), "slave error");
  endtask

  task txchk(input logic [11:0] exp, input int n, input int per);
    logic [11:0] b;
    usc_remote_inst.capture(n, per, b);
    check(32'(b), 32'(exp), "serial frame");
  endtask

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      tally_and_finish();
    end
  end

  initial begin
    logic [7:0] ra [6];
    logic [7:0] rv [6];
    logic [2:0] codes [5];
    logic [1:0] pm;
    logic p;
    ra = '{OFS_CTRL_A, OFS_CTRL_B, OFS_CTRL_C, OFS_BAUD_H, OFS_BAUD_L, 8'h18};
    rv = '{8'h20, RST_CTRL_B, RST_CTRL_C, 8'h00, 8'h00, 8'h00};
    codes = '{3'b000, 3'b001, 3'b010, 3'b011, 3'b111};
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 6; i++) rdc(ra[i], 32'(rv[i]));
    check(32'({tx_data_out, tx_pin_takeover, rx_pin_takeover}), 32'h4, "idle pins");
    $display("test reset done");
    for (int i = 0; i < 5; i++) begin
      wr(OFS_CTRL_C, 32'({codes[i][1:0], 1'b0}));
      wr(OFS_CTRL_B, 32'h9 | (32'(codes[i][2]) << 2));
      wr(OFS_DATA, 32'hb5);
      txchk(12'((9'h1b5 & ((1 << (i + 5)) - 1)) | (1 << (i + 5))), i + 6, 16);
    end
    check(32'(tx_pin_takeover), 32'h1, "transmit takeover");
    check(32'(sync_clock_oe), 32'h0, "sync clock enable");
    $display("test sizes done");
    wr(OFS_CTRL_B, 32'h08);
    for (int k = 1; k < 4; k++) begin
      pm = 2'(k);
      p = (^8'h37) ^ pm[0];
      wr(OFS_CTRL_C, 32'h0e | (32'(pm) << 4));
      wr(OFS_DATA, 32'h37);
      txchk(pm[1] ? 12'({2'b11, p, 8'h37}) : 12'({2'b11, 8'h37}), pm[1] ? 11 : 10, 16);
    end
    $display("test parity done");
    wr(OFS_CTRL_C, 32'h06);
    wr(OFS_BAUD_H, 32'h0a);
    wr(OFS_BAUD_L, 32'h5b);
    rdc(OFS_BAUD_H, 32'h0a);
    rdc(OFS_BAUD_L, 32'h5b);
    wr(OFS_BAUD_H, 32'h0);
    wr(OFS_BAUD_L, 32'h1);
    wr(OFS_DATA, 32'h55);
    txchk(12'h155, 9, 32);
    wr(OFS_CTRL_A, 32'h2);
    wr(OFS_DATA, 32'h55);
    txchk(12'h155, 9, 16);
    wr(OFS_CTRL_A, 32'h0);
    wr(OFS_BAUD_L, 32'h0);
    $display("test rate done");
    wr(OFS_DATA, 32'h5a);
    fork
      txchk(12'h15a, 9, 16);
      begin
        wr(OFS_CTRL_B, 32'h0);
        // the disable must have reached the takeover logic before it is looked at
        repeat (2) @(posedge pclk);
        check(32'(tx_pin_takeover), 32'h1, "takeover while sending");
      end
    join
    for (int w = 0; w < 64 && tx_pin_takeover !== 1'b0; w++) @(posedge pclk);
    check(32'(tx_pin_takeover), 32'h0, "takeover released");
    $display("test disable done");
    wr(OFS_CTRL_C, 32'h36);
    wr(OFS_CTRL_B, 32'h14);
    @(posedge pclk);
    check(32'(rx_pin_takeover), 32'h1, "receive takeover");
    usc_remote_inst.send({1'b1, 1'b1, 9'h1c3}, 11, 16);
    usc_remote_inst.send({1'b0, 1'b1, 9'h0f0}, 11, 16);
    rdc(OFS_CTRL_A, 32'ha4);
    rdc(OFS_CTRL_B, 32'h16);
    rdc(OFS_DATA, 32'hc3);
    rdc(OFS_CTRL_A, 32'hb0);
    rdc(OFS_CTRL_B, 32'h14);
    wr(OFS_CTRL_B, 32'h0);
    rdc(OFS_CTRL_A, 32'h20);
    check(32'(rx_pin_takeover), 32'h0, "receive released");
    check(32'(sync_serial_clock), 32'h0, "serial clock in async mode");
    $display("test receive done");
    wr(OFS_CTRL_C, 32'h46);
    wr(OFS_CTRL_B, 32'h08);
    rdc(OFS_CTRL_C, 32'h46);
    check(32'(sync_clock_oe), 32'h1, "sync clock enable");
    p = sync_serial_clock;
    @(posedge pclk);
    check(32'(sync_serial_clock), 32'(!p), "serial clock runs");
    wr(OFS_DATA, 32'h3c);
    txchk(12'h13c, 9, 2);
    $display("test sync done");
    tally_and_finish();
  end
endmodule // tb_top
